// *** rtl/pic_regs.svh ***
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// register byte offsets
`define PIC_GEN_EN_OFS   12'h000
`define PIC_BLK_EN_OFS   12'h004
`define PIC_VECTOR_OFS   12'h008
`define PIC_FLAGS_OFS    12'h00c
`define PIC_EV_STAT_OFS  12'h010
`define PIC_EV_CLR_OFS   12'h014
`define PIC_EV_EN_OFS    12'h018

// field positions
`define PIC_GIE_BIT      0
`define PIC_ST_ZERO_BIT  0
`define PIC_ST_OVR_BIT   1

// reset values
`define PIC_EN_RST       8'h00
`define PIC_EV_RST       2'h0

// vector layout: (priority number) << shift
`define PIC_VEC_SHIFT    2
`define PIC_NSRC         15

`endif

// *** rtl/pic_pkg.sv ***
package pic_pkg;

  // one-cycle event pulses; packs so that bit 0 is the supply monitor
  typedef struct packed {
    logic       sleep;
    logic       gpio;
    logic [3:0] acol;
    logic [7:0] dblk;
    logic       vmon;
  } pic_src_type;

  typedef enum logic [0:0] {
    PIC_IDLE  = 1'b0,
    PIC_ASKED = 1'b1
  } pic_req_state_type;

endpackage : pic_pkg

// *** rtl/pic_prio_enc.sv ***
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_prio_enc
  import pic_pkg::*;
(
  // requests, bit 0 highest priority
  input  wire logic [`PIC_NSRC-1:0] req,
  // result
  output logic                      valid,
  output logic [3:0]                idx
);

  always_comb
  begin
    valid = 1'b0;
    idx   = 4'h0;
    // scan downward so the lowest index wins
    for (int i = `PIC_NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        valid = 1'b1;
        idx   = 4'(i);
      end
    end
  end

endmodule : pic_prio_enc

// *** rtl/pic_top.sv ***
`timescale 1ns/1ps
`include "pic_regs.svh"

// What this block does
// - latch events from supply monitor, eight digital blocks, four analog columns, I/O, sleep timer
// - every source has its own enable bit in general or block enable register
// - writing one to an enable bit enables that source; zero disables it
// - global enable clear blocks all requests; set passes only individually enabled ones
// - reset clears both enable registers and the global enable bit
// - reading vector register returns vector of highest-priority pending interrupt
// - any write to vector register clears all pending interrupts
// - masking the only pending source after request still gets taken, with vector zero
// - pending latch holds until serviced, reset, or vector register write
// - among several pending, lowest priority number is serviced first
// - vectors four bytes apart: monitor 1, blocks, columns, I/O, sleep timer 15
module pic_top
  import pic_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt sources
  input  wire pic_src_type src,
  // processor core
  output logic             irq_req,
  output logic      [7:0]  irq_vector,
  input  wire logic        irq_ack,
  input  wire logic        irq_reti,
  // system interrupt
  output logic             sys_irq
);

  function automatic logic [7:0] vec_of(input logic [3:0] i);
    return 8'(i + 4'h1) << `PIC_VEC_SHIFT;
  endfunction : vec_of

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    return hit(a, `PIC_GEN_EN_OFS) || hit(a, `PIC_BLK_EN_OFS) ||
           hit(a, `PIC_VECTOR_OFS) || hit(a, `PIC_FLAGS_OFS) ||
           hit(a, `PIC_EV_STAT_OFS) || hit(a, `PIC_EV_CLR_OFS) ||
           hit(a, `PIC_EV_EN_OFS);
  endfunction : mapped

  logic [7:0]            gen_en_q;
  logic [7:0]            blk_en_q;
  logic                  gie_q;
  logic [`PIC_NSRC-1:0]  pend_q;
  logic [`PIC_NSRC-1:0]  pend_d;
  logic [`PIC_NSRC-1:0]  src_vec;
  logic [`PIC_NSRC-1:0]  en_vec;
  logic [`PIC_NSRC-1:0]  act;
  logic [`PIC_NSRC-1:0]  clr_mask;
  logic                  vld;
  logic [3:0]            idx;
  logic [7:0]            vec_live;
  logic [7:0]            vector_q;
  logic [31:0]           rdata_q;
  logic [1:0]            ev_stat_q;
  logic [1:0]            ev_en_q;
  logic [1:0]            ev_set;
  pic_req_state_type     state_q;
  logic                  wr_en;
  logic                  setup_rd;
  logic                  vec_wr;
  logic                  ack_take;

  // apb decode: zero wait states
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped(paddr);
  assign wr_en    = psel && penable && pwrite && mapped(paddr);
  assign setup_rd = psel && !penable && !pwrite;
  assign vec_wr   = wr_en && hit(paddr, `PIC_VECTOR_OFS);
  assign prdata   = rdata_q;

  // source and enable mapping by priority order
  assign src_vec = src;
  assign en_vec  = {gen_en_q[6], gen_en_q[5], gen_en_q[4:1], blk_en_q, gen_en_q[0]};
  assign act     = pend_q & en_vec;

  pic_prio_enc u_enc (
    .req   (act),
    .valid (vld),
    .idx   (idx)
  );

  assign vec_live = vld ? vec_of(idx) : 8'h00;

  // core takes the request; idle slot means zero vector
  assign ack_take = irq_ack && (state_q == PIC_ASKED);

  always_comb
  begin
    clr_mask = {`PIC_NSRC{vec_wr}};
    if (ack_take && vld)
    begin
      clr_mask[idx] = 1'b1;
    end
  end

  // pending latches, new events win over clears
  genvar gi;
  generate
    for (gi = 0; gi < `PIC_NSRC; gi++)
    begin : g_pend
      assign pend_d[gi] = src_vec[gi] | (pend_q[gi] & ~clr_mask[gi]);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pend_q[gi] <= 1'b0;
        else
          pend_q[gi] <= pend_d[gi];
      end
    end
  endgenerate

  // enable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gen_en_q <= `PIC_EN_RST;
      blk_en_q <= `PIC_EN_RST;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `PIC_GEN_EN_OFS))
        gen_en_q <= pwdata[7:0];
      if (hit(paddr, `PIC_BLK_EN_OFS))
        blk_en_q <= pwdata[7:0];
    end
  end

  // global enable: cleared on acknowledge, restored on return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gie_q <= 1'b0;
    else if (ack_take)
      gie_q <= 1'b0;
    else if (irq_reti)
      gie_q <= 1'b1;
    else if (wr_en && hit(paddr, `PIC_FLAGS_OFS))
      gie_q <= pwdata[`PIC_GIE_BIT];
  end

  // request latch: once raised it stays until taken or globally disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= PIC_IDLE;
    else
    begin
      unique case (state_q)
        PIC_IDLE:
          if (gie_q && vld)
            state_q <= PIC_ASKED;
        PIC_ASKED:
          if (ack_take || !gie_q)
            state_q <= PIC_IDLE;
      endcase
    end
  end

  assign irq_req = (state_q == PIC_ASKED);

  // vector presented to the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_q <= 8'h00;
    else
      vector_q <= vec_live;
  end

  assign irq_vector = vector_q;

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h0;
    else if (setup_rd)
    begin
      rdata_q <= 32'h0;
      if (hit(paddr, `PIC_GEN_EN_OFS))
        rdata_q[7:0] <= gen_en_q;
      if (hit(paddr, `PIC_BLK_EN_OFS))
        rdata_q[7:0] <= blk_en_q;
      if (hit(paddr, `PIC_VECTOR_OFS))
        rdata_q[7:0] <= vec_live;
      if (hit(paddr, `PIC_FLAGS_OFS))
        rdata_q[`PIC_GIE_BIT] <= gie_q;
      if (hit(paddr, `PIC_EV_STAT_OFS))
        rdata_q[1:0] <= ev_stat_q;
      if (hit(paddr, `PIC_EV_EN_OFS))
        rdata_q[1:0] <= ev_en_q;
    end
  end

  // block events: zero-vector take, event lost on a pending source
  always_comb
  begin
    ev_set                   = 2'h0;
    ev_set[`PIC_ST_ZERO_BIT] = ack_take && !vld;
    ev_set[`PIC_ST_OVR_BIT]  = |(src_vec & pend_q & ~clr_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_stat_q <= `PIC_EV_RST;
    else if (wr_en && hit(paddr, `PIC_EV_CLR_OFS))
      ev_stat_q <= (ev_stat_q & ~pwdata[1:0]) | ev_set;
    else
      ev_stat_q <= ev_stat_q | ev_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_en_q <= `PIC_EV_RST;
    else if (wr_en && hit(paddr, `PIC_EV_EN_OFS))
      ev_en_q <= pwdata[1:0];
  end

  assign sys_irq = |(ev_stat_q & ev_en_q);

  // checks
  logic after_rst_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      after_rst_q <= 1'b0;
    else
      after_rst_q <= 1'b1;
  end

  sequence s_setup_vec_read;
    psel && !penable && !pwrite && hit(paddr, `PIC_VECTOR_OFS);
  endsequence

  sequence s_vec_write;
    psel && penable && pwrite && hit(paddr, `PIC_VECTOR_OFS);
  endsequence

  a_reset_clears_en: assert property (@(posedge pclk) disable iff (!presetn)
    !after_rst_q |-> (gen_en_q == 8'h00) && (blk_en_q == 8'h00) && !gie_q)
    else $error("enables not clear after reset");

  a_source_latched: assert property (@(posedge pclk) disable iff (!presetn)
    |src_vec |=> ((pend_q & $past(src_vec)) == $past(src_vec)))
    else $error("source event not latched");

  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, `PIC_BLK_EN_OFS)) |=> (blk_en_q == $past(pwdata[7:0])))
    else $error("block enable not stored");

  a_gie_blocks_req: assert property (@(posedge pclk) disable iff (!presetn)
    !gie_q |=> !irq_req)
    else $error("request with global enable clear");

  a_req_raised: assert property (@(posedge pclk) disable iff (!presetn)
    (!irq_req && gie_q && (act != 0)) |=> irq_req)
    else $error("enabled pending source not requested");

  a_vec_read_top: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_vec_read |=> (prdata[7:0] == $past(vec_live)) && (prdata[31:8] == 24'h0))
    else $error("vector read wrong");

  a_vec_write_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_vec_write |=> ((pend_q & ~$past(src_vec)) == 0))
    else $error("vector write left pending");

  a_zero_vec_take: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_req && irq_ack && (act == 0)) |=> ev_stat_q[`PIC_ST_ZERO_BIT] && (irq_vector == 8'h00))
    else $error("zero vector take not flagged");

  a_pend_holds: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (($past(pend_q) & ~$past(clr_mask) & ~pend_q) == 0))
    else $error("pending dropped without clear");

  a_lowest_first: assert property (@(posedge pclk) disable iff (!presetn)
    vld |-> ((act & ((15'h1 << idx) - 15'h1)) == 15'h0))
    else $error("higher priority pending skipped");

  a_vec_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    vld |=> (irq_vector == {2'b00, $past(idx) + 4'h1, 2'b00}))
    else $error("vector spacing wrong");

  sequence s_take;
    irq_req && irq_ack;
  endsequence

  sequence s_gen_write;
    psel && penable && pwrite && hit(paddr, `PIC_GEN_EN_OFS);
  endsequence

  a_take_clears_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (s_take ##0 vld) |=> (!pend_q[$past(idx)] || $past(src_vec[idx])))
    else $error("serviced source still pending");

  a_take_drops_req: assert property (@(posedge pclk) disable iff (!presetn)
    s_take |=> !irq_req && !gie_q)
    else $error("request or global enable kept after take");

  a_mask_keeps_req: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_req && gie_q && !irq_ack) |=> irq_req)
    else $error("request dropped before take");

  a_idle_vec_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !vld |=> (irq_vector == 8'h00))
    else $error("vector not zero with nothing pending");

  a_reset_clears_pend: assert property (@(posedge pclk) disable iff (!presetn)
    !after_rst_q |-> (pend_q == 15'h0) && !irq_req)
    else $error("pending or request left after reset");

  a_gen_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_gen_write |=> (gen_en_q == $past(pwdata[7:0])))
    else $error("general enable not stored");

  a_flags_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, `PIC_FLAGS_OFS) && !ack_take && !irq_reti) |=> (gie_q == $past(pwdata[`PIC_GIE_BIT])))
    else $error("global enable not stored");

  a_reti_sets_gie: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_reti && !ack_take) |=> gie_q)
    else $error("return did not restore global enable");

  a_masked_no_req: assert property (@(posedge pclk) disable iff (!presetn)
    (!irq_req && (act == 15'h0)) |=> !irq_req)
    else $error("request without enabled pending source");

endmodule : pic_top

// *** bench/pic_core_model.sv ***
`timescale 1ns/1ps

module pic_core_model
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // controller side
  input  wire logic       irq_req,
  input  wire logic [7:0] irq_vector,
  output logic            irq_ack,
  output logic            irq_reti,
  // bench side
  input  wire logic       hold,
  output logic      [7:0] last_vec,
  output logic      [7:0] take_cnt
);
  logic [2:0] svc_q;

  // hold stalls the take; service returns after a short handler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ack  <= 1'b0;
      irq_reti <= 1'b0;
      last_vec <= 8'h00;
      take_cnt <= 8'h00;
      svc_q    <= 3'h0;
    end
    else
    begin
      irq_reti <= (svc_q == 3'h1);
      if (svc_q != 3'h0)
        svc_q <= svc_q - 3'h1;
      if (irq_ack)
      begin
        irq_ack  <= 1'b0;
        last_vec <= irq_vector;
        take_cnt <= take_cnt + 8'h01;
        svc_q    <= 3'h4;
      end
      else if (irq_req && !hold && svc_q == 3'h0)
        irq_ack <= 1'b1;
    end
  end
endmodule : pic_core_model

// *** bench/test_pic_top.sv ***
`timescale 1ns/1ps
`include "pic_regs.svh"

module test_pic_top
  import pic_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, err, hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq_req, irq_ack, irq_reti, sys_irq;
  logic [7:0]  irq_vector, last_vec, take_cnt;
  pic_src_type src;
  int          mismatches, num_checks, cyc;

  always #10 pclk = ~pclk;

  pic_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                 .pslverr, .src, .irq_req, .irq_vector, .irq_ack, .irq_reti, .sys_irq);
  pic_core_model core_u (.pclk, .presetn, .irq_req, .irq_vector, .irq_ack, .irq_reti, .hold,
                         .last_vec, .take_cnt);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task pulse(input logic [14:0] m);
    @(posedge pclk);
    src <= pic_src_type'(m);
    @(posedge pclk);
    src <= '0;
  endtask : pulse

  task wait_take(input logic [7:0] n, input logic [7:0] v);
    for (int k = 0; k < 60 && take_cnt !== n; k++)
      @(posedge pclk);
    chk(take_cnt, n);
    chk(last_vec, v);
  endtask : wait_take

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 6000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    {psel, penable, pwrite, hold} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`PIC_GEN_EN_OFS, 32'h0);
    rdchk(`PIC_BLK_EN_OFS, 32'h0);
    rdchk(`PIC_FLAGS_OFS, 32'h0);
    apb(1'b0, 12'h0ff, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `PIC_GEN_EN_OFS, 32'h5a);
    rdchk(`PIC_GEN_EN_OFS, 32'h5a);
    apb(1'b1, `PIC_GEN_EN_OFS, 32'hff);
    apb(1'b1, `PIC_BLK_EN_OFS, 32'h1ff);
    rdchk(`PIC_BLK_EN_OFS, 32'hff);
    $display("regs done");
    for (int i = 0; i < 15; i++)
    begin
      pulse(15'h0001 << i);
      rdchk(`PIC_VECTOR_OFS, (i + 1) << 2);
      apb(1'b1, `PIC_VECTOR_OFS, 32'h5);
      rdchk(`PIC_VECTOR_OFS, 32'h0);
    end
    $display("vectors done");
    pulse(15'h4008);
    repeat (5) @(posedge pclk);
    rdchk(`PIC_VECTOR_OFS, 32'h10);
    chk(irq_req, 1'b0);
    apb(1'b1, `PIC_FLAGS_OFS, 32'h1);
    wait_take(8'h01, 8'h10);
    wait_take(8'h02, 8'h3c);
    rdchk(`PIC_VECTOR_OFS, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b1, `PIC_BLK_EN_OFS, 32'h0);
    pulse(15'h0002);
    repeat (4) @(posedge pclk);
    chk(take_cnt, 8'h02);
    apb(1'b1, `PIC_BLK_EN_OFS, 32'hff);
    wait_take(8'h03, 8'h08);
    repeat (8) @(posedge pclk);
    $display("priority done");
    hold <= 1'b1;
    pulse(15'h0001);
    repeat (3) @(posedge pclk);
    chk(irq_req, 1'b1);
    apb(1'b1, `PIC_GEN_EN_OFS, 32'hfe);
    hold <= 1'b0;
    wait_take(8'h04, 8'h00);
    rdchk(`PIC_EV_STAT_OFS, 32'h1);
    repeat (8) @(posedge pclk);
    apb(1'b1, `PIC_VECTOR_OFS, 32'h0);
    apb(1'b1, `PIC_GEN_EN_OFS, 32'hff);
    apb(1'b1, `PIC_FLAGS_OFS, 32'h0);
    pulse(15'h0001);
    apb(1'b1, `PIC_GEN_EN_OFS, 32'hfe);
    apb(1'b1, `PIC_FLAGS_OFS, 32'h1);
    repeat (6) @(posedge pclk);
    chk(take_cnt, 8'h04);
    $display("zero vector done");
    apb(1'b1, `PIC_EV_CLR_OFS, 32'h3);
    apb(1'b1, `PIC_EV_EN_OFS, 32'h0);
    pulse(15'h0001);
    rdchk(`PIC_EV_STAT_OFS, 32'h2);
    chk(sys_irq, 1'b0);
    apb(1'b1, `PIC_EV_EN_OFS, 32'h2);
    @(posedge pclk);
    chk(sys_irq, 1'b1);
    apb(1'b1, `PIC_EV_STAT_OFS, 32'h0);
    rdchk(`PIC_EV_STAT_OFS, 32'h2);
    rdchk(`PIC_EV_CLR_OFS, 32'h0);
    apb(1'b1, `PIC_EV_CLR_OFS, 32'h2);
    @(posedge pclk);
    chk(sys_irq, 1'b0);
    $display("events done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`PIC_GEN_EN_OFS, 32'h0);
    rdchk(`PIC_BLK_EN_OFS, 32'h0);
    rdchk(`PIC_FLAGS_OFS, 32'h0);
    rdchk(`PIC_VECTOR_OFS, 32'h0);
    $display("reset done");
    test_done();
  end
endmodule : test_pic_top
